// ### verilog/lsc_map.svh
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH
// Register offsets on the management bus
`define LSC_OFF_EQ 8'h1d
`define LSC_OFF_SWING 8'h1e
`define LSC_OFF_DEEMPH 8'h1f
`define LSC_OFF_THR 8'h20
`define LSC_OFF_IDRATE 8'h23
// Reset values
`define LSC_RST_EQ 8'h20
`define LSC_RST_SWING 8'h03
`define LSC_RST_DEEMPH 8'h03
`define LSC_RST_THR 8'h00
`define LSC_RST_IDRATE 8'h00
// Field positions
`define LSC_EQ_EN_BIT 5
`define LSC_EQ_GAIN_HI 4
`define LSC_EQ_GAIN_LO 3
`define LSC_EQ_BOOST_HI 2
`define LSC_DEEMPH_KIND_BIT 7
`define LSC_THR_DEA_HI 3
`define LSC_THR_DEA_LO 2
`define LSC_THR_AS_HI 1
`define LSC_IDLE_AUTO_BIT 5
`define LSC_IDLE_SEL_BIT 4
`define LSC_RATE_AUTO_BIT 1
`define LSC_RATE_SEL_BIT 0
// Device bus address (arbitrary default)
`define LSC_DEV_ADDR 7'h58
`endif

// ### verilog/lsc_pkg.sv
package lsc_pkg;
  // Management bus slave states
  typedef enum logic [3:0] {
    LSC_IDLE, LSC_ADDR, LSC_ADDR_ACK, LSC_REG, LSC_REG_ACK,
    LSC_WDATA, LSC_WDATA_ACK, LSC_RDATA, LSC_RDATA_ACK
  } lsc_state_t;
  // Decoded de-emphasis strength
  typedef enum logic [2:0] {
    LSC_DEEMPH_0DB, LSC_DEEMPH_3P5DB, LSC_DEEMPH_6DB, LSC_DEEMPH_9DB, LSC_DEEMPH_12DB,
    LSC_DEEMPH_OTHER
  } lsc_deemph_db_t;
endpackage

// ### verilog/lsc_reg_if.sv
`timescale 1ns/10ps
interface lsc_reg_if;
  logic wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output wr_stb, output addr, output wdata, input rdata);
  modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ### verilog/lsc_reg_bank.sv
`timescale 1ns/10ps
`include "lsc_map.svh"
module lsc_reg_bank
  import lsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Access from the bus slave
  lsc_reg_if.bank rif,
  // Stored register contents
  output logic [7:0] eq_q,
  output logic [7:0] swing_q,
  output logic [7:0] deemph_q,
  output logic [7:0] thr_q,
  output logic [7:0] idrate_q
);
  // Storage; all bits read back, reserved bits are the host's to keep zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eq_q <= `LSC_RST_EQ;
      swing_q <= `LSC_RST_SWING;
      deemph_q <= `LSC_RST_DEEMPH;
      thr_q <= `LSC_RST_THR;
      idrate_q <= `LSC_RST_IDRATE;
    end else if (rif.wr_stb) begin
      unique case (rif.addr)
        `LSC_OFF_EQ: eq_q <= rif.wdata;
        `LSC_OFF_SWING: swing_q <= rif.wdata;
        `LSC_OFF_DEEMPH: deemph_q <= rif.wdata;
        `LSC_OFF_THR: thr_q <= rif.wdata;
        `LSC_OFF_IDRATE: idrate_q <= rif.wdata;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (rif.addr)
      `LSC_OFF_EQ: rif.rdata = eq_q;
      `LSC_OFF_SWING: rif.rdata = swing_q;
      `LSC_OFF_DEEMPH: rif.rdata = deemph_q;
      `LSC_OFF_THR: rif.rdata = thr_q;
      `LSC_OFF_IDRATE: rif.rdata = idrate_q;
      default: rif.rdata = 8'h00;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  eq_reset_bypass_a: assert property ($rose(rst_n) |-> eq_q == `LSC_RST_EQ)
    else $error("equalizer register not at bypass after reset");
  eq_write_store_a: assert property (
    rif.wr_stb && rif.addr == `LSC_OFF_EQ |=> eq_q == $past(rif.wdata))
    else $error("equalizer write not stored");
endmodule

// ### verilog/lsc_top.sv
`timescale 1ns/10ps
`include "lsc_map.svh"
// Operation
// - Equalizer field: bit 5 enable, bits 4:3 gain stage, bits 2:0 boost.
// - Equalizer resets to 20h, enable set with zero gain: bypass.
// - Strap-equivalent equalizer codes 2A..3D are accepted and decoded.
// - Swing codes 03/07/0F/1F/3F give 600/800/1000/1200/1400 mV.
// - De-emphasis bit 7 picks type, bits 6:0 pick level.
// - De-emphasis 01h gives 0.0 dB, E8h gives -3.5 dB.
// - De-emphasis 88h, 90h, A0h give -6, -9, -12 dB.
// - Idle threshold bits 3:2 de-assert level, bits 1:0 assert level.
// - Threshold codes 0..3 give 110/70, 150/110, 170/130, 190/150 mV.
// - Idle-auto set means automatic idle detect; else idle-select decides.
// - Manual idle-select 1 mutes output; 0 keeps output on, detector off.
// - Rate-auto set means automatic rate detect; else rate-select decides.
// - Manual rate-select 0 gives 2.5 Gbps, 1 gives 5.0 Gbps.
module lsc_top
  import lsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Management bus pins (open drain data)
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Analog detector results for the lanes
  input wire logic idle_detect_i,
  input wire logic rate_detect_i,
  // Second channel receive equalizer
  output logic eq_enable,
  output logic [1:0] gain_stage_sel,
  output logic [2:0] boost_level_sel,
  output logic eq_strap_code,
  // Second channel output buffer
  output logic [6:0] output_swing,
  output logic [10:0] output_swing_mv,
  output logic deemphasis_kind,
  output logic [6:0] deemphasis_setting,
  output lsc_deemph_db_t deemphasis_db,
  // Second channel idle thresholds in mV
  output logic [7:0] idle_deassert_mv,
  output logic [7:0] idle_assert_mv,
  // Third channel idle and rate
  output logic signal_detector,
  output logic lane_mute,
  output logic rate_5g
);
  lsc_reg_if rif ();
  logic [7:0] eq_r, swing_r, deemph_r, thr_r, idrate_r;
  logic scl_m, sda_m, scl_s, sda_s, scl_p, sda_p;
  logic idle_m, idle_s, rate_m, rate_s;
  lsc_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, ptr_q;
  logic wr_q, sda_oe_q, sda_o_q;
  logic scl_rise, scl_fall, start_c, stop_c;

  lsc_reg_bank u_bank (
    .clk(clk),
    .rst_n(rst_n),
    .rif(rif.bank),
    .eq_q(eq_r),
    .swing_q(swing_r),
    .deemph_q(deemph_r),
    .thr_q(thr_r),
    .idrate_q(idrate_r)
  );

  // Swing code to millivolts; unlisted codes read as zero
  function automatic logic [10:0] swing_to_mv(input logic [6:0] c);
    unique case (c)
      7'h03: swing_to_mv = 11'd600;
      7'h07: swing_to_mv = 11'd800;
      7'h0f: swing_to_mv = 11'd1000;
      7'h1f: swing_to_mv = 11'd1200;
      7'h3f: swing_to_mv = 11'd1400;
      default: swing_to_mv = 11'd0;
    endcase
  endfunction

  // Threshold code to millivolts, de-assert or assert column
  function automatic logic [7:0] thr_to_mv(input logic [1:0] c, input logic deassert);
    unique case (c)
      2'd0: thr_to_mv = deassert ? 8'd110 : 8'd70;
      2'd1: thr_to_mv = deassert ? 8'd150 : 8'd110;
      2'd2: thr_to_mv = deassert ? 8'd170 : 8'd130;
      default: thr_to_mv = deassert ? 8'd190 : 8'd150;
    endcase
  endfunction

  // De-emphasis register to strength class
  function automatic lsc_deemph_db_t deemph_class(input logic [7:0] v);
    unique case (v)
      8'h01: deemph_class = LSC_DEEMPH_0DB;
      8'he8: deemph_class = LSC_DEEMPH_3P5DB;
      8'h88: deemph_class = LSC_DEEMPH_6DB;
      8'h90: deemph_class = LSC_DEEMPH_9DB;
      8'ha0: deemph_class = LSC_DEEMPH_12DB;
      default: deemph_class = LSC_DEEMPH_OTHER;
    endcase
  endfunction

  // Strap-equivalent equalizer settings
  function automatic logic eq_is_strap(input logic [5:0] v);
    unique case (v)
      6'h20, 6'h2a, 6'h30, 6'h32, 6'h35, 6'h37, 6'h39, 6'h3b, 6'h3d: eq_is_strap = 1'b1;
      default: eq_is_strap = 1'b0;
    endcase
  endfunction

  // Pin synchronisers; first stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_p} <= 3'b111;
      {sda_m, sda_s, sda_p} <= 3'b111;
      {idle_m, idle_s, rate_m, rate_s} <= 4'h0;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
      idle_m <= idle_detect_i;
      idle_s <= idle_m;
      rate_m <= rate_detect_i;
      rate_s <= rate_m;
    end
  end

  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_c = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c = scl_s & scl_p & ~sda_p & sda_s;

  // Register port: pointer addresses the bank, write strobe for one cycle
  assign rif.addr = ptr_q;
  assign rif.wdata = shift_q;
  assign rif.wr_stb = wr_q;

  // Bus slave: data sampled on SCL rise, SDA changed on SCL fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= LSC_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      wr_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (start_c) begin
        state_q <= LSC_ADDR;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_c) begin
        state_q <= LSC_IDLE;
        sda_oe_q <= 1'b0;
      end else if (scl_rise) begin
        unique case (state_q)
          LSC_ADDR, LSC_REG, LSC_WDATA: begin
            if (cnt_q < 4'd8) begin
              shift_q <= {shift_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'd1;
            end
          end
          LSC_RDATA: cnt_q <= cnt_q + 4'd1;
          // Master NACK ends the read burst
          LSC_RDATA_ACK: if (sda_s) state_q <= LSC_IDLE;
          default: ;
        endcase
      end else if (scl_fall) begin
        unique case (state_q)
          LSC_ADDR: begin
            if (cnt_q == 4'd8 && shift_q[7:1] == `LSC_DEV_ADDR) begin
              sda_oe_q <= 1'b1;
              state_q <= LSC_ADDR_ACK;
            end else if (cnt_q == 4'd8) begin
              state_q <= LSC_IDLE; // Other device addressed
            end
          end
          LSC_REG: begin
            if (cnt_q == 4'd8) begin
              ptr_q <= shift_q;
              sda_oe_q <= 1'b1;
              state_q <= LSC_REG_ACK;
            end
          end
          LSC_WDATA: begin
            if (cnt_q == 4'd8) begin
              wr_q <= 1'b1;
              sda_oe_q <= 1'b1;
              state_q <= LSC_WDATA_ACK;
            end
          end
          LSC_ADDR_ACK: begin
            cnt_q <= 4'h0;
            if (shift_q[0]) begin
              // Read: first bit goes out right after the ack
              sda_oe_q <= ~rif.rdata[7];
              shift_q <= {rif.rdata[6:0], 1'b0};
              state_q <= LSC_RDATA;
            end else begin
              sda_oe_q <= 1'b0;
              state_q <= LSC_REG;
            end
          end
          LSC_REG_ACK, LSC_WDATA_ACK: begin
            // Pointer advances after each write so bursts walk the map
            if (state_q == LSC_WDATA_ACK) ptr_q <= ptr_q + 8'h01;
            sda_oe_q <= 1'b0;
            cnt_q <= 4'h0;
            state_q <= LSC_WDATA;
          end
          LSC_RDATA: begin
            if (cnt_q == 4'd8) begin
              sda_oe_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              state_q <= LSC_RDATA_ACK;
            end else begin
              sda_oe_q <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
          LSC_RDATA_ACK: begin
            cnt_q <= 4'h0;
            sda_oe_q <= ~rif.rdata[7];
            shift_q <= {rif.rdata[6:0], 1'b0};
            state_q <= LSC_RDATA;
          end
          default: ;
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sda_o_q <= 1'b0;
    else sda_o_q <= 1'b0;
  end
  assign sda_o = sda_o_q;
  assign sda_oe = sda_oe_q;

  // Equalizer and output buffer fields, registered for clean analog controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eq_enable <= 1'b1;
      gain_stage_sel <= 2'd0;
      boost_level_sel <= 3'd0;
      eq_strap_code <= 1'b1;
      output_swing <= 7'h03;
      output_swing_mv <= 11'd600;
      deemphasis_kind <= 1'b0;
      deemphasis_setting <= 7'h03;
      deemphasis_db <= LSC_DEEMPH_OTHER;
    end else begin
      eq_enable <= eq_r[`LSC_EQ_EN_BIT];
      gain_stage_sel <= eq_r[`LSC_EQ_GAIN_HI:`LSC_EQ_GAIN_LO];
      boost_level_sel <= eq_r[`LSC_EQ_BOOST_HI:0];
      eq_strap_code <= eq_is_strap(eq_r[5:0]);
      output_swing <= swing_r[6:0];
      output_swing_mv <= swing_to_mv(swing_r[6:0]);
      deemphasis_kind <= deemph_r[`LSC_DEEMPH_KIND_BIT];
      deemphasis_setting <= deemph_r[6:0];
      deemphasis_db <= deemph_class(deemph_r);
    end
  end

  // Idle thresholds and third channel idle/rate selection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_deassert_mv <= 8'd110;
      idle_assert_mv <= 8'd70;
      signal_detector <= 1'b0;
      lane_mute <= 1'b0;
      rate_5g <= 1'b0;
    end else begin
      idle_deassert_mv <= thr_to_mv(thr_r[`LSC_THR_DEA_HI:`LSC_THR_DEA_LO], 1'b1);
      idle_assert_mv <= thr_to_mv(thr_r[`LSC_THR_AS_HI:0], 1'b0);
      // Detector runs only in automatic mode; manual 0 keeps it off
      signal_detector <= idrate_r[`LSC_IDLE_AUTO_BIT];
      lane_mute <= idrate_r[`LSC_IDLE_AUTO_BIT] ? idle_s
                                               : idrate_r[`LSC_IDLE_SEL_BIT];
      rate_5g <= idrate_r[`LSC_RATE_AUTO_BIT] ? rate_s
                                             : idrate_r[`LSC_RATE_SEL_BIT];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  eq_gain_map_a: assert property (
    ##1 gain_stage_sel == $past(eq_r[4:3]) && boost_level_sel == $past(eq_r[2:0]))
    else $error("equalizer fields misplaced");
  eq_strap_flag_a: assert property ($past(eq_r[5:0]) == 6'h39 |-> eq_strap_code)
    else $error("strap code not recognised");
  swing_600mv_a: assert property ($past(swing_r[6:0]) == 7'h03 |-> output_swing_mv == 11'd600)
    else $error("swing 03h not 600 mV");
  swing_1400mv_a: assert property ($past(swing_r[6:0]) == 7'h3f |-> output_swing_mv == 11'd1400)
    else $error("swing 3Fh not 1400 mV");
  deemph_kind_bit_a: assert property (##1 deemphasis_kind == $past(deemph_r[7]))
    else $error("de-emphasis type not from bit 7");
  deemph_3p5_db_a: assert property (
    $past(deemph_r) == 8'he8 |-> deemphasis_db == LSC_DEEMPH_3P5DB)
    else $error("E8h not -3.5 dB");
  deemph_12_db_a: assert property (
    $past(deemph_r) == 8'ha0 |-> deemphasis_db == LSC_DEEMPH_12DB)
    else $error("A0h not -12 dB");
  thr_code_two_a: assert property (
    $past(thr_r[3:0]) == 4'b1001 |-> idle_deassert_mv == 8'd170 && idle_assert_mv == 8'd110)
    else $error("threshold decode wrong");
  idle_manual_mute_a: assert property (
    $past(idrate_r[5:4]) == 2'b01 |-> lane_mute && !signal_detector)
    else $error("manual idle not muting");
  idle_auto_follow_a: assert property ($past(idrate_r[5]) |-> lane_mute == $past(idle_s))
    else $error("auto idle not following detector");
  rate_manual_sel_a: assert property (
    !$past(idrate_r[1]) |-> rate_5g == $past(idrate_r[0]))
    else $error("manual rate not applied");
endmodule

// ### dv/lsc_host_model.sv
`timescale 1ns/10ps
`include "lsc_map.svh"
module lsc_host_model (
  // Clock
  input wire logic clk,
  // Resolved data line
  input wire logic sda_in,
  // Bus clock and data pull-down
  output logic scl_q,
  output logic sda_oe_q
);
  // Bus idle at time zero: both lines released
  initial begin
    scl_q = 1'b1;
    sda_oe_q = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves mid low phase only, phases of 10 clk
  task automatic put_bit(input logic b);
    sda_oe_q <= ~b;
    tick(5);
    scl_q <= 1'b1;
    tick(10);
    scl_q <= 1'b0;
    tick(5);
  endtask
  task automatic get_bit(output logic b);
    sda_oe_q <= 1'b0;
    tick(5);
    scl_q <= 1'b1;
    tick(5);
    b = sda_in;
    tick(5);
    scl_q <= 1'b0;
    tick(5);
  endtask
  // Also serves as repeated start
  task automatic start();
    sda_oe_q <= 1'b0;
    tick(5);
    scl_q <= 1'b1;
    tick(10);
    sda_oe_q <= 1'b1;
    tick(10);
    scl_q <= 1'b0;
    tick(5);
  endtask
  task automatic stop();
    sda_oe_q <= 1'b1;
    tick(5);
    scl_q <= 1'b1;
    tick(10);
    sda_oe_q <= 1'b0;
    tick(10);
  endtask
  // Byte MSB first, then the slave's acknowledge (high means refused)
  task automatic send(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(nack);
  endtask
  // One or two data bytes; the pointer advances between them
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] off,
                        input logic [15:0] data, input logic two, output logic nack);
    logic n0, n1, n2, n3;
    n3 = 1'b0;
    start();
    send({dev, 1'b0}, n0);
    send(off, n1);
    if (two) begin
      send(data[15:8], n3);
    end
    send(data[7:0], n2);
    stop();
    nack = n0 | n1 | n2 | n3;
  endtask
  // Pointer set by a write phase, then repeated start and one byte read
  task automatic rd_reg(input logic [7:0] off, output logic [7:0] data, output logic nack);
    logic n0, n1, n2;
    start();
    send({`LSC_DEV_ADDR, 1'b0}, n0);
    send(off, n1);
    start();
    send({`LSC_DEV_ADDR, 1'b1}, n2);
    for (int i = 7; i >= 0; i--) begin
      get_bit(data[i]);
    end
    put_bit(1'b1);
    stop();
    nack = n0 | n1 | n2;
  endtask
endmodule

// ### dv/tb_lane_signal_config_regs.sv
`timescale 1ns/10ps
`include "lsc_map.svh"
module tb_lane_signal_config_regs
  import lsc_pkg::*;
();
  logic clk, rst_n, scl, host_oe, sda_o_w, sda_oe_w, idle_det, rate_det;
  logic eq_en, eq_strap, deemph_kind, sig_det, mute, rate5;
  logic [1:0] gain;
  logic [2:0] boost;
  logic [6:0] swing, deemph_set;
  logic [10:0] swing_mv;
  logic [7:0] dea_mv, as_mv;
  lsc_deemph_db_t deemph_db;
  wire sda_line;
  int n_mismatch = 0;
  int checked = 0;
  logic nk;
  logic [7:0] rd;
  logic [7:0] offs [5] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h23};
  logic [7:0] rsts [5] = '{8'h20, 8'h03, 8'h03, 8'h00, 8'h00};
  logic [7:0] eqc [8] = '{8'h2a, 8'h30, 8'h32, 8'h35, 8'h37, 8'h39, 8'h3b, 8'h3d};
  logic [7:0] swc [5] = '{8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f};
  logic [7:0] deemph_codes [5] = '{8'h01, 8'he8, 8'h88, 8'h90, 8'ha0};
  logic [7:0] dea [4] = '{8'd110, 8'd150, 8'd170, 8'd190};
  logic [7:0] asl [4] = '{8'd70, 8'd110, 8'd130, 8'd150};

  // Open-drain data with pull-up
  assign sda_line = !(host_oe || (sda_oe_w && !sda_o_w));

  // Clock at 100 MHz
  initial clk = 1'b0;
  always #5 clk = ~clk;

  lsc_host_model host_u (.clk(clk), .sda_in(sda_line), .scl_q(scl), .sda_oe_q(host_oe));

  lsc_top dut_u (
    .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o_w),
    .sda_oe(sda_oe_w), .idle_detect_i(idle_det), .rate_detect_i(rate_det),
    .eq_enable(eq_en), .gain_stage_sel(gain), .boost_level_sel(boost),
    .eq_strap_code(eq_strap), .output_swing(swing), .output_swing_mv(swing_mv),
    .deemphasis_kind(deemph_kind), .deemphasis_setting(deemph_set), .deemphasis_db(deemph_db),
    .idle_deassert_mv(dea_mv), .idle_assert_mv(as_mv), .signal_detector(sig_det),
    .lane_mute(mute), .rate_5g(rate5)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Reserved bits always written as zero by callers
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    host_u.wr_reg(`LSC_DEV_ADDR, off, {8'h00, d}, 1'b0, nk);
    check(16'(nk), 16'h0000);
  endtask
  task automatic rdc(input logic [7:0] off, input logic [7:0] exp);
    host_u.rd_reg(off, rd, nk);
    check({7'h00, nk, rd}, {8'h00, exp});
  endtask
  task automatic give_verdict();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    idle_det = 1'b0;
    rate_det = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Outputs and registers straight out of reset
    check(16'({eq_en, gain, boost, eq_strap}), 16'h0041);
    check(16'(swing_mv), 16'd600);
    check(16'({deemph_kind, deemph_set}), 16'h0003);
    check(16'({dea_mv, as_mv}), {8'd110, 8'd70});
    check(16'({sig_det, mute, rate5}), 16'h0000);
    for (int i = 0; i < 5; i++) rdc(offs[i], rsts[i]);
    // Strap-equivalent equalizer codes, then a non-strap code
    for (int i = 0; i < 8; i++) begin
      wr(8'h1d, eqc[i]);
      check(16'({eq_en, gain, boost}), 16'(eqc[i][5:0]));
      check(16'(eq_strap), 16'h0001);
    end
    rdc(8'h1d, 8'h3d);
    wr(8'h1d, 8'h15);
    check(16'({eq_en, gain, boost, eq_strap}), 16'h002a);
    // Swing codes in 200 mV steps
    for (int i = 0; i < 5; i++) begin
      wr(8'h1e, swc[i]);
      check(16'(swing), 16'(swc[i]));
      check(16'(swing_mv), 16'(600 + 200 * i));
    end
    // De-emphasis codes; the reserved code is never written
    for (int i = 0; i < 5; i++) begin
      wr(8'h1f, deemph_codes[i]);
      check(16'({deemph_kind, deemph_set}), 16'(deemph_codes[i]));
      check(16'(deemph_db), 16'(i));
    end
    // Both threshold fields at once, walked in opposite directions
    for (int i = 0; i < 4; i++) begin
      wr(8'h20, 8'((i << 2) | (3 - i)));
      check({dea_mv, as_mv}, {dea[i], asl[3 - i]});
    end
    // Manual idle and rate selection
    wr(8'h23, 8'h10);
    check(16'({sig_det, mute, rate5}), 16'h0002);
    wr(8'h23, 8'h01);
    check(16'({sig_det, mute, rate5}), 16'h0001);
    // Automatic mode ignores the select bits and follows the detectors
    wr(8'h23, 8'h33);
    check(16'({sig_det, mute, rate5}), 16'h0004);
    idle_det <= 1'b1;
    rate_det <= 1'b1;
    repeat (6) @(posedge clk);
    check(16'({sig_det, mute, rate5}), 16'h0007);
    wr(8'h23, 8'h02);
    check(16'({sig_det, mute, rate5}), 16'h0001);
    // Two-byte write with pointer advance, unmapped read, foreign address
    host_u.wr_reg(`LSC_DEV_ADDR, 8'h1e, 16'h1f88, 1'b1, nk);
    check(16'({nk, swing_mv}), 16'd1200);
    check(16'(deemph_db), 16'(LSC_DEEMPH_6DB));
    rdc(8'h21, 8'h00);
    host_u.wr_reg(7'h59, 8'h1d, 16'h0030, 1'b0, nk);
    check(16'(nk), 16'h0001);
    rdc(8'h1d, 8'h15);
    // Mid-run reset with the bus idle; written values must not survive it
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(16'({eq_en, gain, boost, eq_strap}), 16'h0041);
    check(16'({deemph_kind, deemph_set}), 16'h0003);
    for (int i = 0; i < 5; i++) rdc(offs[i], rsts[i]);
    give_verdict();
  end
endmodule
